// ### common/fss_pkg.sv
package fss_pkg;
	// Speed words are signed rpm
	localparam int SPW = 16;
	typedef logic signed [SPW-1:0] fss_speed_t;

	// Register byte offsets on the APB port
	localparam logic [7:0] OFF_MODE = 8'h00;
	localparam logic [7:0] OFF_FIELDBUS = 8'h04;
	localparam logic [7:0] OFF_SEL_SRC = 8'h08;
	localparam logic [7:0] OFF_JOG_SRC = 8'h0c;
	localparam logic [7:0] OFF_JOG_SPD = 8'h10;
	localparam logic [7:0] OFF_LIMITS = 8'h14;
	localparam logic [7:0] OFF_RAMP = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1c;
	localparam logic [1:0] TBL_REGION = 2'h1;

	// Mode select values
	localparam logic [7:0] MODE_DIRECT = 8'h01;
	localparam logic [7:0] MODE_BINARY = 8'h02;

	// Signal source codes: high nibble picks the word, low nibble the bit
	localparam logic [3:0] SRC_OFF = 4'h0;
	localparam logic [3:0] SRC_DIN = 4'h1;
	localparam logic [3:0] SRC_FB = 4'h2;

	// Reset values
	localparam logic [7:0] RST_MODE = MODE_DIRECT;
	localparam logic [31:0] RST_SEL_SRC = 32'h00151413;
	localparam logic [15:0] RST_JOG_SRC = 16'h0000;
	localparam logic [15:0] RST_JOG_SPD = 16'h0096;
	localparam logic [15:0] RST_FIX_SPD = 16'h0000;
	localparam logic [15:0] RST_MIN_SPD = 16'h0000;
	localparam logic [15:0] RST_MAX_SPD = 16'h05dc;
	localparam logic [15:0] RST_RAMP_STEP = 16'h0001;

	// Field positions
	localparam int LIM_MAX_LSB = 16;
	localparam int JOG2_LSB = 16;
	localparam int ST_LSB = 16;
	localparam int SELV_LSB = 20;

	// Ramp tick timing
	localparam int CLK_MHZ = 125;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = TICK_US * CLK_MHZ;

	typedef enum logic [1:0] {ST_OFF, ST_ON, ST_JOG1, ST_JOG2} fss_state_t;
endpackage

// ### common/fss_sel_if.sv
`timescale 1ns/1ns
interface fss_sel_if;
	logic [3:0] sel;
	logic binMode;
	fss_pkg::fss_speed_t tbl [16];
	fss_pkg::fss_speed_t total;

	modport ctrl(output sel, output binMode, output tbl, input total);
	modport calc(input sel, input binMode, input tbl, output total);
endinterface

// ### design/fss_select.sv
`timescale 1ns/1ns
module fss_select (
	// Selection signals, table and result
	fss_sel_if.calc s
);
	// Direct mode sums, binary mode indexes; result saturates to 16 bits
	always_comb begin
		logic signed [17:0] acc;
		acc = '0;
		if (s.binMode) begin
			acc = 18'(s.tbl[s.sel]);
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (s.sel[i]) begin
					acc = acc + 18'(s.tbl[i]);
				end
			end
		end
		// In direct mode nothing selected leaves acc at zero speed; binary mode with sel at zero picks entry 0
		if (acc > 18'sh07fff) begin
			s.total = 16'sh7fff;
		end else if (acc < -18'sh08000) begin
			s.total = -16'sh8000;
		end else begin
			s.total = acc[15:0];
		end
	end
endmodule

// ### design/fss_top.sv
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
// Functional notes
// - Sixteen fixed setpoints, selected from digital inputs or fieldbus bits.
// - Direct mode: each signal owns one setpoint; active ones are summed.
// - Binary mode: each signal combination picks one setpoint.
// - Mode value one means direct selection, and is the reset default.
// - The four direct setpoints reset to zero speed.
// - Sources of setpoints one to three default to digital inputs 3-5.
// - Source value zero is always inactive; fourth source defaults to it.
// - Jog is ignored while the motor runs; partner jogs only when off.
// - Jog switches motor on to jog speed; releasing it switches off.
// - Two jog command sources, each defaulting to inactive zero.
// - Each jog has its own speed, both defaulting to 150 rpm.
// - Chosen setpoint is clamped to min/max speed and ramped.
module fss_top #(
	parameter int TICK_CYCLES = fss_pkg::TICK_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins
	input wire logic onCmd,
	input wire logic [15:0] digIn,
	// Towards motor control
	output fss_pkg::fss_speed_t speedSetpoint,
	output logic motorOn,
	output logic jogActive
);
	// Byte-lane merge of a write into an old word
	function automatic logic [31:0] mergeStrb(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Resolve one signal source code to a bit
	function automatic logic srcBit(input logic [7:0] src,
		input logic [15:0] din, input logic [15:0] fb);
		logic b;
		b = 1'b0;
		if (src[7:4] == fss_pkg::SRC_DIN) begin
			b = din[src[3:0]];
		end else if (src[7:4] == fss_pkg::SRC_FB) begin
			b = fb[src[3:0]];
		end
		// SRC_OFF and unused codes stay low
		return b;
	endfunction

	// Clamp magnitude between min and max, keeping the sign
	function automatic fss_pkg::fss_speed_t clampSpd(
		input fss_pkg::fss_speed_t v, input logic [15:0] lo,
		input logic [15:0] hi);
		logic [16:0] mag;
		logic [16:0] lim;
		mag = v[15] ? 17'(-$signed({v[15], v})) : {1'b0, v};
		lim = mag;
		if (lim > {1'b0, hi}) begin
			lim = {1'b0, hi};
		end
		if (lim < {1'b0, lo}) begin
			lim = {1'b0, lo};
		end
		return v[15] ? 16'(-$signed(lim)) : lim[15:0];
	endfunction

	// Pin synchronisers: first stage feeds only the second
	logic [16:0] pinMeta_reg;
	logic [16:0] pinSync_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pinMeta_reg <= '0;
			pinSync_reg <= '0;
		end else begin
			pinMeta_reg <= {onCmd, digIn};
			pinSync_reg <= pinMeta_reg;
		end
	end
	logic onSync;
	logic [15:0] dinSync;
	assign onSync = pinSync_reg[16];
	assign dinSync = pinSync_reg[15:0];

	// Configuration registers
	logic [7:0] mode_reg;
	logic [15:0] fieldbus_reg;
	logic [31:0] selSrc_reg;
	logic [15:0] jogSrc_reg;
	logic [31:0] jogSpd_reg;
	logic [31:0] limits_reg;
	logic [15:0] rampStep_reg;
	fss_pkg::fss_speed_t tbl_reg [16];

	// APB access phase; one wait state so every answer is from a flop
	logic access;
	logic wrFire;
	logic tblHit;
	logic [3:0] tblIdx;
	assign access = psel & penable;
	assign wrFire = access & pready & pwrite;
	assign tblHit = paddr[7:6] == fss_pkg::TBL_REGION;
	assign tblIdx = paddr[5:2];

	// Register writes take effect on the edge that completes the transfer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_reg <= fss_pkg::RST_MODE;
			fieldbus_reg <= '0;
			selSrc_reg <= fss_pkg::RST_SEL_SRC;
			jogSrc_reg <= fss_pkg::RST_JOG_SRC;
			jogSpd_reg <= {2{fss_pkg::RST_JOG_SPD}};
			limits_reg <= {fss_pkg::RST_MAX_SPD, fss_pkg::RST_MIN_SPD};
			rampStep_reg <= fss_pkg::RST_RAMP_STEP;
		end else if (wrFire && paddr[1:0] == 2'h0) begin
			unique case (paddr)
				fss_pkg::OFF_MODE:
					mode_reg <= 8'(mergeStrb(32'(mode_reg), pwdata, pstrb));
				fss_pkg::OFF_FIELDBUS:
					fieldbus_reg <= 16'(mergeStrb(32'(fieldbus_reg),
						pwdata, pstrb));
				fss_pkg::OFF_SEL_SRC:
					selSrc_reg <= mergeStrb(selSrc_reg, pwdata, pstrb);
				fss_pkg::OFF_JOG_SRC:
					jogSrc_reg <= 16'(mergeStrb(32'(jogSrc_reg),
						pwdata, pstrb));
				fss_pkg::OFF_JOG_SPD:
					jogSpd_reg <= mergeStrb(jogSpd_reg, pwdata, pstrb);
				fss_pkg::OFF_LIMITS:
					limits_reg <= mergeStrb(limits_reg, pwdata, pstrb);
				fss_pkg::OFF_RAMP:
					rampStep_reg <= 16'(mergeStrb(32'(rampStep_reg),
						pwdata, pstrb));
				default: begin
				end
			endcase
		end
	end

	// Fixed setpoint table; entries 0-3 serve direct mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 16; i++) begin
				tbl_reg[i] <= fss_pkg::RST_FIX_SPD;
			end
		end else if (wrFire && tblHit && paddr[1:0] == 2'h0) begin
			tbl_reg[tblIdx] <= 16'(mergeStrb(32'(tbl_reg[tblIdx]),
				pwdata, pstrb));
		end
	end

	// Selection and jog signals resolved through their sources
	logic [3:0] sel_reg;
	logic [1:0] jog_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sel_reg <= '0;
			jog_reg <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				sel_reg[i] <= srcBit(selSrc_reg[i*8 +: 8], dinSync,
					fieldbus_reg);
			end
			for (int j = 0; j < 2; j++) begin
				jog_reg[j] <= srcBit(jogSrc_reg[j*8 +: 8], dinSync,
					fieldbus_reg);
			end
		end
	end

	// Setpoint selection in its own module
	fss_sel_if selBus();
	assign selBus.sel = sel_reg;
	assign selBus.binMode = mode_reg == fss_pkg::MODE_BINARY;
	assign selBus.tbl = tbl_reg;
	fss_select uSelect (
		.s(selBus.calc)
	);

	// Total is registered to keep the adder off the ramp path
	fss_pkg::fss_speed_t total_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			total_reg <= '0;
		end else begin
			total_reg <= selBus.total;
		end
	end

	// Motor on/off with jog; jog only starts from the off state
	fss_pkg::fss_state_t state_reg;
	fss_pkg::fss_state_t state_next;
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			fss_pkg::ST_OFF: begin
				if (onSync) begin
					state_next = fss_pkg::ST_ON;
				end else if (jog_reg[0]) begin
					state_next = fss_pkg::ST_JOG1;
				end else if (jog_reg[1]) begin
					state_next = fss_pkg::ST_JOG2;
				end
			end
			fss_pkg::ST_ON: begin
				// Jog requests are not looked at here
				if (!onSync) begin
					state_next = fss_pkg::ST_OFF;
				end
			end
			fss_pkg::ST_JOG1: begin
				if (!jog_reg[0]) begin
					state_next = fss_pkg::ST_OFF;
				end
			end
			fss_pkg::ST_JOG2: begin
				if (!jog_reg[1]) begin
					state_next = fss_pkg::ST_OFF;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= fss_pkg::ST_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// Target speed: fixed total, one of two jog speeds, or zero when off
	fss_pkg::fss_speed_t target;
	always_comb begin
		unique case (state_reg)
			fss_pkg::ST_ON:
				target = total_reg;
			fss_pkg::ST_JOG1:
				target = jogSpd_reg[15:0];
			fss_pkg::ST_JOG2:
				target = jogSpd_reg[fss_pkg::JOG2_LSB +: 16];
			default:
				target = '0;
		endcase
	end

	// Clamp only while running, so switching off ramps down to zero
	fss_pkg::fss_speed_t clamped;
	assign clamped = (state_reg == fss_pkg::ST_OFF) ? '0 :
		clampSpd(target, limits_reg[15:0],
		limits_reg[fss_pkg::LIM_MAX_LSB +: 16]);

	// Ramp tick divider
	localparam int TW = $clog2(TICK_CYCLES + 1);
	logic [TW-1:0] tickCnt_reg;
	logic tick_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tickCnt_reg <= '0;
			tick_reg <= 1'b0;
		end else if (tickCnt_reg == TW'(TICK_CYCLES - 1)) begin
			tickCnt_reg <= '0;
			tick_reg <= 1'b1;
		end else begin
			tickCnt_reg <= tickCnt_reg + 1'b1;
			tick_reg <= 1'b0;
		end
	end

	// Ramp: move toward the clamped target by at most one step per tick
	logic signed [17:0] diff;
	logic signed [17:0] step;
	assign diff = 18'(clamped) - 18'(speedSetpoint);
	assign step = {2'b00, rampStep_reg};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			speedSetpoint <= '0;
		end else if (tick_reg) begin
			if (diff > step) begin
				speedSetpoint <= 16'(18'(speedSetpoint) + step);
			end else if (diff < -step) begin
				speedSetpoint <= 16'(18'(speedSetpoint) - step);
			end else begin
				speedSetpoint <= clamped;
			end
		end
	end

	// Motor state outputs straight from flops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			motorOn <= 1'b0;
			jogActive <= 1'b0;
		end else begin
			motorOn <= state_next != fss_pkg::ST_OFF;
			jogActive <= state_next == fss_pkg::ST_JOG1 ||
				state_next == fss_pkg::ST_JOG2;
		end
	end

	// Read mux and error decode
	logic [31:0] rdNext;
	logic errNext;
	always_comb begin
		rdNext = '0;
		errNext = 1'b0;
		if (paddr[1:0] != 2'h0) begin
			errNext = 1'b1;
		end else if (tblHit) begin
			rdNext = 32'(unsigned'(tbl_reg[tblIdx]));
		end else begin
			unique case (paddr)
				fss_pkg::OFF_MODE:
					rdNext = 32'(mode_reg);
				fss_pkg::OFF_FIELDBUS:
					rdNext = 32'(fieldbus_reg);
				fss_pkg::OFF_SEL_SRC:
					rdNext = selSrc_reg;
				fss_pkg::OFF_JOG_SRC:
					rdNext = 32'(jogSrc_reg);
				fss_pkg::OFF_JOG_SPD:
					rdNext = jogSpd_reg;
				fss_pkg::OFF_LIMITS:
					rdNext = limits_reg;
				fss_pkg::OFF_RAMP:
					rdNext = 32'(rampStep_reg);
				fss_pkg::OFF_STATUS: begin
					rdNext[15:0] = speedSetpoint;
					rdNext[fss_pkg::ST_LSB +: 2] = state_reg;
					rdNext[fss_pkg::SELV_LSB +: 4] = sel_reg;
				end
				default:
					errNext = 1'b1;
			endcase
		end
		// Status is read-only; a write to it is refused
		if (pwrite && paddr == fss_pkg::OFF_STATUS) begin
			errNext = 1'b1;
		end
	end

	// APB answer one cycle into the access phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			pready <= access & ~pready;
			pslverr <= access & ~pready & errNext;
			if (access && !pready && !pwrite) begin
				prdata <= rdNext;
			end
		end
	end
endmodule

// ### sim/fss_panel_model.sv
`timescale 1ns/1ns
// Switch panel and input terminals on the far side of the block
module fss_panel_model (
	// Clock
	input wire logic clk,
	// Pins into the block
	output logic onCmd,
	output logic [15:0] digIn
);
	// Quiet levels from time zero
	initial begin
		onCmd = 1'b0;
		digIn = 16'h0000;
	end

	// Levels move just after an edge, as a terminal scan would
	task setOn(input logic v);
		@(posedge clk);
		onCmd <= v;
	endtask

	// Input levels move just after an edge; any pattern a test gives is driven, motor on or off
	task setDin(input logic [15:0] v);
		@(posedge clk);
		digIn <= v;
	endtask
endmodule

// ### sim/fss_top_assertions.sv
`timescale 1ns/1ns
module fss_top_assertions #(
	parameter int TICK_CYCLES = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// Motor side
	input wire logic onCmd,
	input wire fss_pkg::fss_speed_t speedSetpoint,
	input wire logic motorOn,
	input wire logic jogActive
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Cycles since the last setpoint step; saturates so it never wraps
	int gapCnt;
	logic gapValid;
	fss_pkg::fss_speed_t lastSpeed;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gapCnt <= 0;
			gapValid <= 1'b0;
			lastSpeed <= 16'sh0000;
		end else begin
			lastSpeed <= speedSetpoint;
			if (speedSetpoint != lastSpeed) begin
				gapCnt <= 1;
				gapValid <= 1'b1;
			end else if (gapCnt < TICK_CYCLES) begin
				gapCnt <= gapCnt + 1;
			end
		end
	end

	sequence sAccess;
		$rose(penable) && psel;
	endsequence
	sequence sOnPress;
		$rose(onCmd) && !motorOn && !jogActive ##1 onCmd [*5];
	endsequence
	sequence sOffPress;
		$fell(onCmd) && motorOn && !jogActive ##1 !onCmd [*5];
	endsequence

	AST_ONE_WAIT: assert property (sAccess |-> !pready ##1 pready)
		else $error("pready not after one wait state");
	AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
		else $error("pready outside an access");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_JOG_MEANS_ON: assert property (jogActive |-> motorOn)
		else $error("jog active with motor off");
	AST_NO_JOG_WHILE_ON: assert property (
		motorOn && !jogActive |=> !jogActive)
		else $error("jog accepted while running");
	AST_ON_RESPONSE: assert property (sOnPress |-> motorOn)
		else $error("motor did not switch on");
	AST_OFF_RESPONSE: assert property (sOffPress |-> !motorOn)
		else $error("motor did not switch off");
	AST_SPEED_GAP: assert property (gapValid && speedSetpoint != lastSpeed
		|-> gapCnt >= TICK_CYCLES)
		else $error("setpoint stepped between ramp ticks");
endmodule

bind fss_top fss_top_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk (
	.clk(clk),
	.rst(rst),
	.psel(psel),
	.penable(penable),
	.pready(pready),
	.pslverr(pslverr),
	.onCmd(onCmd),
	.speedSetpoint(speedSetpoint),
	.motorOn(motorOn),
	.jogActive(jogActive)
);

// ### sim/tb_fixed_speed_setpoint_select.sv
`timescale 1ns/1ns
module tb_fixed_speed_setpoint_select;
	localparam int TCK = 8;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic onCmd;
	logic [15:0] digIn;
	fss_pkg::fss_speed_t speedSetpoint;
	logic motorOn;
	logic jogActive;
	logic [31:0] rd;
	logic err;
	int failures = 0;
	int comparisons = 0;

	// 125 MHz
	always #4 clk = ~clk;

	fss_top #(.TICK_CYCLES(TCK)) dut (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.onCmd(onCmd), .digIn(digIn), .speedSetpoint(speedSetpoint),
		.motorOn(motorOn), .jogActive(jogActive)
	);
	fss_panel_model panel (.clk(clk), .onCmd(onCmd), .digIn(digIn));

	task wrap_up;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task check(input string what, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			wrap_up();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdChk(input string what, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(what, rd, e);
	endtask

	// Ramp settles within a bounded number of cycles
	task waitSpeed(input string what, input logic [15:0] e);
		int n;
		n = 0;
		while (speedSetpoint !== e && n < 3000) begin
			@(posedge clk);
			n++;
		end
		check(what, {16'h0, speedSetpoint}, {16'h0, e});
		if (n >= 3000)
			wrap_up();
	endtask

	task pins(input logic on, input logic jog);
		repeat (8) @(posedge clk);
		check("motorOn", {31'h0, motorOn}, {31'h0, on});
		check("jogActive", {31'h0, jogActive}, {31'h0, jog});
	endtask

	task testReset;
		rdChk("mode", fss_pkg::OFF_MODE, 32'h1);
		rdChk("sources", fss_pkg::OFF_SEL_SRC, 32'h00151413);
		rdChk("jog src", fss_pkg::OFF_JOG_SRC, 32'h0);
		rdChk("jog spd", fss_pkg::OFF_JOG_SPD, 32'h00960096);
		for (int i = 0; i < 4; i++)
			rdChk("fixed", 8'h40 + 8'(4 * i), 32'h0);
		rdChk("unmapped", 8'h30, 32'h0);
		check("unmapped err", {31'h0, err}, 32'h1);
		rdChk("misaligned", 8'h02, 32'h0);
		check("misaligned err", {31'h0, err}, 32'h1);
		wr(fss_pkg::OFF_STATUS, 32'h0000ffff);
		check("status err", {31'h0, err}, 32'h1);
		$display("reset test done");
	endtask

	task testDirect;
		wr(fss_pkg::OFF_RAMP, 32'h7d0);
		for (int i = 0; i < 4; i++)
			wr(8'h40 + 8'(4 * i), 32'(100 * (i + 1)));
		panel.setOn(1'b1);
		waitSpeed("none", 16'd0);
		panel.setDin(16'h0018);
		waitSpeed("two", 16'd300);
		panel.setDin(16'h0078);
		waitSpeed("locked", 16'd600);
		wr(fss_pkg::OFF_SEL_SRC, 32'h16151413);
		waitSpeed("four", 16'd1000);
		rdChk("selects", fss_pkg::OFF_STATUS, 32'h00f103e8);
		wr(8'h40, 32'h7d0);
		waitSpeed("clamp", 16'd1500);
		wr(fss_pkg::OFF_RAMP, 32'd50);
		panel.setDin(16'h0000);
		repeat (2 * TCK) @(posedge clk);
		check("ramp", {31'h0, speedSetpoint >= 16'sd1350}, 32'h1);
		waitSpeed("down", 16'd0);
		panel.setOn(1'b0);
		pins(1'b0, 1'b0);
		$display("direct test done");
	endtask

	task testBinary;
		wr(fss_pkg::OFF_MODE, 32'h2);
		wr(fss_pkg::OFF_RAMP, 32'h7d0);
		wr(fss_pkg::OFF_SEL_SRC, 32'h23222120);
		for (int i = 0; i < 16; i++)
			wr(8'h40 + 8'(4 * i), 32'(i * 64 + 5));
		panel.setOn(1'b1);
		for (int c = 0; c < 16; c++) begin
			wr(fss_pkg::OFF_FIELDBUS, 32'(c));
			waitSpeed("binary", 16'(c * 64 + 5));
		end
		panel.setOn(1'b0);
		wr(fss_pkg::OFF_MODE, 32'h1);
		pins(1'b0, 1'b0);
		$display("binary test done");
	endtask

	task testJog;
		wr(fss_pkg::OFF_JOG_SRC, 32'h1413);
		wr(fss_pkg::OFF_JOG_SPD, 32'h00c80064);
		panel.setDin(16'h0008);
		pins(1'b1, 1'b1);
		waitSpeed("jog one", 16'd100);
		panel.setDin(16'h0000);
		pins(1'b0, 1'b0);
		panel.setDin(16'h0010);
		pins(1'b1, 1'b1);
		waitSpeed("jog two", 16'd200);
		panel.setDin(16'h0000);
		pins(1'b0, 1'b0);
		panel.setOn(1'b1);
		pins(1'b1, 1'b0);
		panel.setDin(16'h0008);
		pins(1'b1, 1'b0);
		panel.setOn(1'b0);
		panel.setDin(16'h0000);
		$display("jog test done");
	endtask

	// Byte lanes, far input bits, signed sums, saturation and min clamp
	task testSources;
		wr(fss_pkg::OFF_MODE, 32'h3);
		pstrb <= 4'hc;
		wr(fss_pkg::OFF_LIMITS, 32'h01f4ffff);
		pstrb <= 4'h3;
		rdChk("lane hi", fss_pkg::OFF_LIMITS, 32'h01f40000);
		wr(fss_pkg::OFF_LIMITS, 32'hffff0064);
		pstrb <= 4'hf;
		rdChk("lane lo", fss_pkg::OFF_LIMITS, 32'h01f40064);
		wr(fss_pkg::OFF_SEL_SRC, 32'h1f1e1d10);
		wr(8'h40, 32'd300);
		wr(8'h44, 32'hffffff38);
		wr(8'h48, 32'h00007000);
		wr(8'h4c, 32'h00007000);
		panel.setOn(1'b1);
		waitSpeed("min", 16'd100);
		panel.setDin(16'h0001);
		waitSpeed("bit0", 16'd300);
		panel.setDin(16'h2001);
		waitSpeed("signed sum", 16'd100);
		panel.setDin(16'h2000);
		waitSpeed("reverse", 16'hff38);
		panel.setDin(16'hc000);
		waitSpeed("saturate", 16'd500);
		panel.setDin(16'h1f87);
		waitSpeed("unused bits", 16'd300);
		panel.setOn(1'b0);
		panel.setDin(16'h0000);
		pins(1'b0, 1'b0);
		waitSpeed("stop", 16'd0);
		$display("sources test done");
	endtask

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		testReset();
		testDirect();
		testBinary();
		testJog();
		testSources();
		wrap_up();
	end
endmodule
